/* inc/fosc_cfg.svh */
// Purpose: offsets, field positions, reset values and timing for fosc
// Assumes: byte-wide register port, 125 MHz reference clock
// Notes:   included by the block, the checker and the bench
`ifndef FOSC_CFG_SVH
`define FOSC_CFG_SVH

// ****************************************************************
// Register offsets (byte index on the register port)
// ****************************************************************
`define FOSC_OFS_OPT       4'h0
`define FOSC_OFS_CFG       4'h1
`define FOSC_OFS_CLKDIV    4'h2
`define FOSC_OFS_STATUS    4'h3
`define FOSC_OFS_KEY       4'h4
`define FOSC_OFS_BLANK     4'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define FOSC_BIT_BACKDOOR_ENABLE     7
`define FOSC_BIT_NORED     6
`define FOSC_SEC_HI        1
`define FOSC_SEC_LO        0
`define FOSC_BIT_KEY_ACCESS_CONTROL    5
`define FOSC_BIT_PRESCALE  6
`define FOSC_DIV_HI        5

// ****************************************************************
// Values
// ****************************************************************
`define FOSC_SEC_UNSECURE  2'h2
`define FOSC_KEY_BYTES     8
`define FOSC_CLKDIV_RESET  8'h00
`define FOSC_PRE_RATIO     8

// Program/erase pulse limits in ns, clock period in ns
`define FOSC_PULSE_MIN_NS  5000
`define FOSC_PULSE_MAX_NS  6700
`define FOSC_CLK_NS        8

`endif

/* inc/fosc_pkg.sv */
// Purpose: types shared by the flash option and security block
// Assumes: fosc_cfg.svh on the include path
// Notes:   types only; numbers live in the header
package fosc_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fosc_bus_t;

  typedef struct packed {
    logic       backdoor_enable;
    logic       nored;
    logic [1:0] sec;
  } fosc_opt_t;

  typedef enum logic [1:0] {
    FOSC_KEY_IDLE,
    FOSC_KEY_COLLECT,
    FOSC_KEY_DONE
  } fosc_key_state_t;
endpackage

/* hdl/fosc_top.sv */
// Purpose: flash options load, security state, backdoor key, clock divider
// Assumes: nonvolatile bytes and key are stable inputs from the array
// Notes:   register port with one-cycle read latency, no wait states
`timescale 1ns/1ps
`default_nettype none
`include "fosc_cfg.svh"

// Notes on behaviour
// - Byte-wide registers; nonvolatile option byte mirrored into working register.
// - Divided flash clock period must lie between 5 and 6.7 us; the divider reaches at most 512 cycles (4.096 us) and only flags it.
// - Every reset reloads working options from the nonvolatile byte.
// - Backdoor enable clear refuses every key attempt.
// - Eight matching key bytes in order release security until reset.
// - Key writes accepted only from secure code, never from debug.
// - Redirect disable bit one turns vector redirection off.
// - Secure state blocks unsecured requesters from RAM and flash.
// - Key match or full blank check forces code to unsecure.
// - Only code 1:0 is unsecure; other three codes are secure.
// - Blocked writes do nothing, blocked reads return zero.
// - Set key access, write eight bytes, clearing it compares.
module fosc_top
  import fosc_pkg::*;
#(
  parameter int PRE_RATIO = `FOSC_PRE_RATIO
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire fosc_bus_t  i_bus,
  input  wire logic       i_bus_from_secure,
  input  wire logic       i_bus_from_debug,
  input  wire logic [7:0] i_nonvolatile_option_byte,
  input  wire logic [63:0] i_stored_unlock_key,
  input  wire logic       i_blank_check_pass,
  input  wire logic       i_mem_req,
  input  wire logic       i_mem_req_secure,
  input  wire logic       i_mem_req_wr,
  input  wire logic [7:0] i_mem_rdata,
  output logic      [7:0] o_rdata,
  output logic            o_secure,
  output logic            o_redirect_enable,
  output logic            o_mem_wr_enable,
  output logic      [7:0] o_mem_rdata,
  output logic            o_divided_flash_clock_en
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // decode security code
  function automatic logic fosc_is_secure(input logic [1:0] code);
    return code != `FOSC_SEC_UNSECURE;
  endfunction

  localparam int PULSE_MIN_CYC =
    (`FOSC_PULSE_MIN_NS + `FOSC_CLK_NS - 1) / `FOSC_CLK_NS;
  localparam int PULSE_MAX_CYC = `FOSC_PULSE_MAX_NS / `FOSC_CLK_NS;
  // Limits in reference cycles; the minimum rounds up so a period
  // one cycle short of the limit is still reported

  // ****************************************************************
  // Option, security and config state
  // ****************************************************************
  fosc_opt_t        opt_r, opt_nxt;
  logic             loaded_r, loaded_nxt;
  logic             key_access_control_r, key_access_control_nxt;
  logic             prescale_r, prescale_nxt;
  logic [5:0]       div_r, div_nxt;
  logic [63:0]      key_buf_r, key_buf_nxt;
  logic [3:0]       key_cnt_r, key_cnt_nxt;
  logic             key_bad_r, key_bad_nxt;
  fosc_key_state_t  kst_r, kst_nxt;
  logic [7:0]       opt_byte;
  logic             wr_opt_ok;

  assign opt_byte = {opt_r.backdoor_enable, opt_r.nored, 4'h0, opt_r.sec};
  // Debug commands reach the bus but never feed the comparison
  // key source check
  assign wr_opt_ok = i_bus_from_secure && !i_bus_from_debug;

  // Working options are zero in reset, which decodes as secure;
  // the real byte lands one cycle after release, so the outputs
  // hold the secure and no-redirect levels until then
  always_comb begin
    opt_nxt      = opt_r;
    loaded_nxt   = 1'b1;
    key_access_control_nxt   = key_access_control_r;
    prescale_nxt = prescale_r;
    div_nxt      = div_r;
    key_buf_nxt  = key_buf_r;
    key_cnt_nxt  = key_cnt_r;
    key_bad_nxt  = key_bad_r;
    kst_nxt      = kst_r;
    if (!loaded_r) begin
      opt_nxt.backdoor_enable = i_nonvolatile_option_byte[`FOSC_BIT_BACKDOOR_ENABLE];
      opt_nxt.nored = i_nonvolatile_option_byte[`FOSC_BIT_NORED];
      opt_nxt.sec   = i_nonvolatile_option_byte[`FOSC_SEC_HI:`FOSC_SEC_LO];
    end
    if (i_bus.wr && i_bus.addr == `FOSC_OFS_CLKDIV) begin
      prescale_nxt = i_bus.wdata[`FOSC_BIT_PRESCALE];
      div_nxt      = i_bus.wdata[`FOSC_DIV_HI:0];
    end
    // Bytes shift in at the low end so the first lands in the top
    // bits, as the stored key is laid out. A ninth byte marks the
    // attempt bad instead of wrapping, so over-long entry never matches
    case (kst_r)
      FOSC_KEY_IDLE: begin
        if (i_bus.wr && i_bus.addr == `FOSC_OFS_CFG && wr_opt_ok &&
            i_bus.wdata[`FOSC_BIT_KEY_ACCESS_CONTROL]) begin
          key_access_control_nxt  = 1'b1;
          key_cnt_nxt = 4'h0;
          key_bad_nxt = 1'b0;
          kst_nxt     = FOSC_KEY_COLLECT;
        end
      end
      FOSC_KEY_COLLECT: begin
        if (i_bus.wr && i_bus.addr == `FOSC_OFS_KEY && wr_opt_ok) begin
          key_buf_nxt = {key_buf_r[55:0], i_bus.wdata};
          if (key_cnt_r == 4'(`FOSC_KEY_BYTES))
            key_bad_nxt = 1'b1;
          else
            key_cnt_nxt = key_cnt_r + 4'h1;
        end
        if (i_bus.wr && i_bus.addr == `FOSC_OFS_CFG && wr_opt_ok &&
            !i_bus.wdata[`FOSC_BIT_KEY_ACCESS_CONTROL]) begin
          key_access_control_nxt = 1'b0;
          kst_nxt    = FOSC_KEY_DONE;
        end
      end
      FOSC_KEY_DONE: begin
        if (opt_r.backdoor_enable && !key_bad_r &&
            key_cnt_r == 4'(`FOSC_KEY_BYTES) &&
            key_buf_r == i_stored_unlock_key)
          opt_nxt.sec = `FOSC_SEC_UNSECURE;
        // Wiped so a stale entry cannot be compared again
        key_buf_nxt = 64'h0;
        kst_nxt     = FOSC_KEY_IDLE;
      end
      default: kst_nxt = FOSC_KEY_IDLE;
    endcase
    // Blank check outranks the key path in the same cycle
    // blank check unsecures
    if (loaded_r && i_blank_check_pass)
      opt_nxt.sec = `FOSC_SEC_UNSECURE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      opt_r      <= '0;
      loaded_r   <= 1'b0;
      key_access_control_r   <= 1'b0;
      prescale_r <= 1'b0;
      div_r      <= 6'h00;
      key_buf_r  <= 64'h0;
      key_cnt_r  <= 4'h0;
      key_bad_r  <= 1'b0;
      kst_r      <= FOSC_KEY_IDLE;
    end else begin
      opt_r      <= opt_nxt;
      loaded_r   <= loaded_nxt;
      key_access_control_r   <= key_access_control_nxt;
      prescale_r <= prescale_nxt;
      div_r      <= div_nxt;
      key_buf_r  <= key_buf_nxt;
      key_cnt_r  <= key_cnt_nxt;
      key_bad_r  <= key_bad_nxt;
      kst_r      <= kst_nxt;
    end
  end

  // ****************************************************************
  // Flash clock divider
  // ****************************************************************
  logic [2:0] pre_cnt_r, pre_cnt_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic       fclk_r, fclk_nxt;
  logic       pre_tick;

  // Limitation: a new divisor is compared with the running count at once, so the
  // first pulse after a change may follow neither the old nor the new setting.
  // Prescale counter idles at zero while divide-by-eight is off.
  // prescale then divisor plus one
  assign pre_tick = !prescale_r || pre_cnt_r == 3'(PRE_RATIO - 1);

  always_comb begin
    pre_cnt_nxt = pre_tick ? 3'h0 : pre_cnt_r + 3'h1;
    div_cnt_nxt = div_cnt_r;
    fclk_nxt    = 1'b0;
    if (pre_tick) begin
      if (div_cnt_r >= div_r) begin
        div_cnt_nxt = 6'h00;
        fclk_nxt    = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      fclk_r    <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      fclk_r    <= fclk_nxt;
    end
  end

  // ****************************************************************
  // Period check for the divided clock (status only)
  // ****************************************************************
  // Status only: software reads the flag, nothing else depends on it
  // flag periods outside limits
  logic [15:0] per_cnt_r, per_cnt_nxt;
  logic        per_bad_r, per_bad_nxt;
  always_comb begin
    per_cnt_nxt = fclk_r ? 16'h0001 :
                  (per_cnt_r == 16'hFFFF ? per_cnt_r : per_cnt_r + 16'h0001);
    per_bad_nxt = per_bad_r;
    if (fclk_r && per_cnt_r != 16'h0000)
      per_bad_nxt = (32'(per_cnt_r) < PULSE_MIN_CYC) ||
                    (32'(per_cnt_r) > PULSE_MAX_CYC);
    // New divisor restarts the judgement of the period
    if (i_bus.wr && i_bus.addr == `FOSC_OFS_CLKDIV)
      per_bad_nxt = 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      per_cnt_r <= 16'h0000;
      per_bad_r <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      per_bad_r <= per_bad_nxt;
    end
  end

  // ****************************************************************
  // Register read, memory gate and outputs
  // ****************************************************************
  logic [7:0] rdata_nxt;
  logic       sec_now;
  logic       mem_block;

  // Gate follows the live code, so access opens in the same cycle
  // that the working code changes
  assign sec_now   = fosc_is_secure(opt_r.sec);
  assign mem_block = sec_now && !i_mem_req_secure;

  // Zero outside a strobe so read data stand for one cycle only
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `FOSC_OFS_OPT:    rdata_nxt = opt_byte;
        `FOSC_OFS_CFG:    rdata_nxt = {2'h0, key_access_control_r, 5'h00};
        `FOSC_OFS_CLKDIV: rdata_nxt = {1'b0, prescale_r, div_r};
        `FOSC_OFS_STATUS: rdata_nxt = {5'h00, per_bad_r, loaded_r, sec_now};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata                  <= 8'h00;
      o_secure                 <= 1'b1;
      o_redirect_enable        <= 1'b0;
      o_mem_wr_enable          <= 1'b0;
      o_mem_rdata              <= 8'h00;
      o_divided_flash_clock_en <= 1'b0;
    end else begin
      o_rdata                  <= rdata_nxt;
      // Held secure until the option byte has been loaded
      o_secure                 <= sec_now || !loaded_r;
      o_redirect_enable        <= loaded_r && !opt_r.nored;
      o_mem_wr_enable          <= i_mem_req && i_mem_req_wr && !mem_block;
      o_mem_rdata              <= (i_mem_req && !mem_block) ? i_mem_rdata
                                                            : 8'h00;
      o_divided_flash_clock_en <= fclk_r;
    end
  end

endmodule
`default_nettype wire

/* sim/fosc_properties.sv */
// Purpose: port assertions for fosc_top
// Assumes: one clock, synchronous reset
// Notes:   attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
`include "fosc_cfg.svh"
module fosc_checker
  import fosc_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire fosc_bus_t  i_bus,
  input wire logic [7:0] i_nonvolatile_option_byte,
  input wire logic       i_blank_check_pass,
  input wire logic       i_mem_req,
  input wire logic       i_mem_req_secure,
  input wire logic       i_mem_req_wr,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_secure,
  input wire logic       o_redirect_enable,
  input wire logic       o_mem_wr_enable,
  input wire logic [7:0] o_mem_rdata
);
  // ****
  // Checks
  // ****
  wire logic opt_rd = i_bus.rd && i_bus.addr == `FOSC_OFS_OPT;
  // Secure requesters always pass
  wire logic m_ok   = i_mem_req_secure || !o_secure;
  wire logic m_rd   = i_mem_req && !i_mem_req_wr;
  wire logic m_wr   = i_mem_req && i_mem_req_wr;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  rd_slot_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  opt_load_a: assert property (opt_rd |=> o_rdata[5:2] == 4'h0 &&
    o_rdata[7:6] == i_nonvolatile_option_byte[7:6])
    else $error("option read differs from option byte");
  redir_a: assert property ($past(opt_rd) |-> o_redirect_enable == !o_rdata[6])
    else $error("redirect output disagrees with option bit");
  blk_rd_a: assert property (m_rd && !m_ok |=> o_mem_rdata == 8'h00)
    else $error("blocked read returned data");
  blk_wr_a: assert property (m_wr && !m_ok |=> !o_mem_wr_enable)
    else $error("blocked write permitted");
  pass_rd_a: assert property (m_rd && m_ok |=> o_mem_rdata == $past(i_mem_rdata))
    else $error("allowed read lost data");
  pass_wr_a: assert property (m_wr && m_ok |=> o_mem_wr_enable)
    else $error("allowed write refused");
  stay_open_a: assert property (!o_secure |=> !o_secure)
    else $error("security came back without reset");
  blank_open_a: assert property (i_blank_check_pass |-> ##[1:4] !o_secure)
    else $error("blank check did not unsecure");
  cover property ($fell(o_secure));
  cover property (m_rd && !m_ok);
  cover property (opt_rd);
endmodule

bind fosc_top fosc_checker chk_u (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(i_bus),
  .i_nonvolatile_option_byte(i_nonvolatile_option_byte),
  .i_blank_check_pass(i_blank_check_pass), .i_mem_req(i_mem_req),
  .i_mem_req_secure(i_mem_req_secure), .i_mem_req_wr(i_mem_req_wr),
  .i_mem_rdata(i_mem_rdata), .o_rdata(o_rdata), .o_secure(o_secure),
  .o_redirect_enable(o_redirect_enable), .o_mem_wr_enable(o_mem_wr_enable),
  .o_mem_rdata(o_mem_rdata)
);
`default_nettype wire

/* sim/test_flash_option_security_control.sv */
// Purpose: self-checking bench for fosc_top
// Assumes: 125 MHz clock, bench drives all ports
// Notes:   divider range flag is always set at this clock rate
`timescale 1ns/1ps
`default_nettype none
`include "fosc_cfg.svh"
module test_flash_option_security_control
  import fosc_pkg::*;
;
  localparam logic [63:0] KEY = 64'hA5C3_1E77_0F9B_D246;
  logic       clk, rst, src, dbg, blank, mreq, msec, mwr;
  fosc_bus_t  bus;
  logic [7:0] nv, rdata, mdout;
  logic       secure, redir, mwe, fen;
  int         err_count = 0;
  int         total_checks = 0;
  fosc_top dut_u (
    .i_ref_clk(clk), .i_reset(rst), .i_bus(bus), .i_bus_from_secure(src),
    .i_bus_from_debug(dbg), .i_nonvolatile_option_byte(nv),
    .i_stored_unlock_key(KEY), .i_blank_check_pass(blank),
    .i_mem_req(mreq), .i_mem_req_secure(msec), .i_mem_req_wr(mwr),
    .i_mem_rdata(8'h5A), .o_rdata(rdata), .o_secure(secure),
    .o_redirect_enable(redir), .o_mem_wr_enable(mwe),
    .o_mem_rdata(mdout), .o_divided_flash_clock_en(fen)
  );
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // ****
  // Helpers
  // ****
  task automatic chk(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Step past the edge so outputs have settled
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic reset_with(input logic [7:0] opt);
    rst <= 1'h1;
    nv <= opt;
    go(8);
    rst <= 1'h0;
    go(3);
  endtask
  task automatic mem(input logic s, w);
    @(posedge clk);
    mreq <= 1'h1;
    msec <= s;
    mwr <= w;
    @(posedge clk);
    mreq <= 1'h0;
    #1;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_options();
    logic [7:0] d;
    for (int c = 0; c < 4; c++) begin
      reset_with({c[1], c[0], 4'hF, c[1:0]});
      rd(`FOSC_OFS_OPT, d);
      chk("option reg", {c[1], c[0], 4'h0, c[1:0]}, d);
      chk("secure", c != 2, secure);
      chk("redirect", !c[0], redir);
      rd(`FOSC_OFS_BLANK, d);
      chk("unmapped", 8'h00, d);
    end
  endtask
  task automatic t_gate();
    reset_with(8'h03);
    mem(1'h0, 1'h0);
    chk("blocked read", 8'h00, mdout);
    mem(1'h0, 1'h1);
    chk("blocked write", 1'h0, mwe);
    mem(1'h1, 1'h1);
    chk("secure write", 1'h1, mwe);
    mem(1'h1, 1'h0);
    chk("secure read", 8'h5A, mdout);
  endtask
  task automatic t_key(input logic en, d_src, input int n,
                       input logic [63:0] k, input logic exp);
    logic [7:0] d;
    reset_with({en, 7'h03});
    src <= !d_src;
    dbg <= d_src;
    wr(`FOSC_OFS_CFG, 8'h20);
    for (int i = 0; i < n; i++) wr(`FOSC_OFS_KEY, k[63-8*i -: 8]);
    wr(`FOSC_OFS_CFG, 8'h00);
    go(4);
    chk("key secure", exp, secure);
    rd(`FOSC_OFS_OPT, d);
    chk("key code", exp ? 2'h3 : 2'h2, d[1:0]);
  endtask
  task automatic t_blank();
    int i;
    reset_with(8'h03);
    blank <= 1'h1;
    go(1);
    blank <= 1'h0;
    for (i = 0; i < 8 && secure !== 1'h0; i++) go(1);
    chk("blank unsecure", 1'h0, secure);
    if (i == 8) close_out();
  endtask
  task automatic t_div(input logic pre, input logic [5:0] dv, input int per);
    logic [7:0] d;
    int n;
    wr(`FOSC_OFS_CLKDIV, {1'h0, pre, dv});
    rd(`FOSC_OFS_CLKDIV, d);
    chk("clkdiv", {1'h0, pre, dv}, d);
    // First pulse after a change may follow neither setting
    repeat (2) begin
      for (n = 0; n < 2000 && fen !== 1'h1; n++) go(1);
      go(1);
    end
    for (n = 1; n < 2000 && fen !== 1'h1; n++) go(1);
    chk("period", per, n);
    if (n >= 2000) close_out();
    // Flag restarts on the divisor write; judged once pulses have run
    rd(`FOSC_OFS_STATUS, d);
    chk("range flag", 1'h1, d[2]);
  endtask
  initial begin
    rst = 1'h1;
    bus = '0;
    nv = 8'h00;
    src = 1'h1;
    dbg = 1'h0;
    blank = 1'h0;
    mreq = 1'h0;
    msec = 1'h0;
    mwr = 1'h0;
    t_options();
    t_gate();
    t_key(1'h0, 1'h0, 8, KEY, 1'h1);
    t_key(1'h1, 1'h1, 8, KEY, 1'h1);
    t_key(1'h1, 1'h0, 7, KEY, 1'h1);
    t_key(1'h1, 1'h0, 8, KEY ^ 64'h1, 1'h1);
    t_key(1'h1, 1'h0, 8, KEY, 1'h0);
    t_blank();
    t_div(1'h1, 6'h0C, 104);
    t_div(1'h0, 6'h31, 50);
    t_div(1'h0, 6'h00, 1);
    close_out();
  end
endmodule
`default_nettype wire
